// >>> adf_pkg.sv
package adf_pkg;
   // serial word layout
   localparam int WORD_BITS   = 16;
   localparam int INDEX_BITS  = 7;
   localparam int VALUE_BITS  = 8;
   localparam int CNT_BITS    = 5;
   localparam int RW_POS      = 15;
   // register indices
   localparam logic [6:0] IDX_RESET  = 7'h00;
   localparam logic [6:0] IDX_FORMAT = 7'h04;
   localparam int RESET_BIT = 7;
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   // data format register fields
   localparam int TP_HI     = 5;
   localparam int TP_LO     = 3;
   localparam int POL_BIT   = 2;
   localparam int SCR_BIT   = 1;
   localparam int SIGN_BIT  = 0;
   localparam logic [5:0] FORMAT_USED = 6'h3f;
   // test pattern codes
   localparam logic [2:0] TP_OFF    = 3'h0;
   localparam logic [2:0] TP_ZEROS  = 3'h1;
   localparam logic [2:0] TP_ONES   = 3'h3;
   localparam logic [2:0] TP_CHECK  = 3'h5;
   localparam logic [2:0] TP_TOGGLE = 3'h7;
   // 15-bit pattern words, overrange flag on top, then 14-bit coding masks
   localparam logic [14:0] CHECK_A  = 15'h5555;
   localparam logic [14:0] CHECK_B  = 15'h2aaa;
   localparam logic [14:0] ALL_ONE  = 15'h7fff;
   localparam logic [14:0] ALL_ZERO = 15'h0000;
   localparam logic [13:0] MSB_ONLY = 14'h2000;
   localparam logic [13:0] ALT_MASK = 14'h2aaa;
endpackage

// >>> adf_formatter.sv
`timescale 1ns/1ps
// Functional notes
// [R1] pattern select 000 passes normal conversion results.
// [R2] pattern select 001 drives overrange flag and sample bits all zero.
// [R3] pattern select 011 drives overrange flag and sample bits all one.
// [R4] pattern select 101 alternates checkerboard words each sample.
// [R5] pattern select 111 alternates all zeros and all ones each sample.
// [R6] software writes only codes 000,001,011,101,111 to pattern select.
// [R7] bit 2 enables alternate bit polarity output mode.
// [R8] bit 1 enables the output randomizer.
// [R9] bit 0 selects offset binary (0) or two's complement (1).
// [R10] bits 7 and 6 of the format register are ignored.
// [R11] serial word: read/write flag, seven index bits, eight data bits.
// [R12] sample data on first 16 serial clock rises; chip select high ends.
// [R13] reset bit 7 at index 00h clears format register; self-clears.
// [R14] test patterns bypass coding, polarity and randomizer.
module adf_formatter #(
   parameter int SAMPLE_BITS = 14
) (
   input  wire logic                   clock,         // conversion clock
   input  wire logic                   reset,         // sync, active high
   input  wire logic [SAMPLE_BITS-1:0] conv_sample,   // raw offset binary
   input  wire logic                   conv_over,     // raw overrange
   input  wire logic                   sel_n,         // serial chip select
   input  wire logic                   serial_clock,  // serial clock pin
   input  wire logic                   serial_in,     // serial data in
   output logic                        serial_out_o,  // open drain data
   output logic                        serial_out_oe, // high while pulling
   output logic [SAMPLE_BITS-1:0]      sample_bits,   // formatted sample
   output logic                        overrange_flag // formatted flag
);
   // pin synchronisers, two stages before any logic
   logic [1:0] sel_sync;
   logic [1:0] sck_sync;
   logic [1:0] sdi_sync;
   logic       sck_prev;
   always_ff @(posedge clock) begin
      if (reset) begin
         sel_sync <= 2'h3;
         sck_sync <= 2'h0;
         sdi_sync <= 2'h0;
         sck_prev <= 1'b0;
      end else begin
         sel_sync <= {sel_sync[0], sel_n};
         sck_sync <= {sck_sync[0], serial_clock};
         sdi_sync <= {sdi_sync[0], serial_in};
         sck_prev <= sck_sync[1];
      end
   end

   wire selected = ~sel_sync[1];
   wire sck_rise = selected & sck_sync[1] & ~sck_prev;

   // serial word shifter, edges past the sixteenth are dropped
   logic [adf_pkg::WORD_BITS-1:0] shift;
   logic [adf_pkg::CNT_BITS-1:0]  bit_cnt;
   logic                          sel_prev;
   localparam logic [4:0] FULL = 5'(adf_pkg::WORD_BITS);
   localparam logic [4:0] HDR  = 5'(adf_pkg::INDEX_BITS + 1); // flag, index
   wire take_bit  = sck_rise & (bit_cnt < FULL);            // [R12]
   wire frame_end = sel_prev & ~selected;                    // [R12]
   wire word_full = (bit_cnt == FULL);
   wire is_read   = shift[adf_pkg::RW_POS];                  // [R11]
   wire [6:0] w_index = shift[14:8];                         // [R11]
   wire [7:0] w_value = shift[7:0];
   wire do_write  = frame_end & word_full & ~is_read;        // [R11]
   wire sw_reset  = do_write & (w_index == adf_pkg::IDX_RESET)
                    & w_value[adf_pkg::RESET_BIT];           // [R13]
   wire fmt_write = do_write & (w_index == adf_pkg::IDX_FORMAT);

   always_ff @(posedge clock) begin
      if (reset) begin
         shift    <= '0;
         bit_cnt  <= '0;
         sel_prev <= 1'b0;
      end else begin
         sel_prev <= selected;
         if (!selected) begin
            bit_cnt <= '0;
         end else if (take_bit) begin
            shift   <= {shift[14:0], sdi_sync[1]};
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // format register; bits 7:6 are not stored, reset bit never stored
   logic [5:0] fmt;
   always_ff @(posedge clock) begin
      if (reset || sw_reset) begin
         fmt <= adf_pkg::FORMAT_RESET[5:0];                  // [R13]
      end else if (fmt_write) begin
         fmt <= w_value[5:0] & adf_pkg::FORMAT_USED;         // [R10]
      end
   end

   // register checks; a read or a cut frame must leave the register alone
   chk_soft_reset: assert property ( // [R13]
      @(posedge clock) disable iff (reset)
      sw_reset |=> fmt == adf_pkg::FORMAT_RESET[5:0])
      else $error("soft reset did not clear format");
   chk_format_write: assert property ( // [R10]
      @(posedge clock) disable iff (reset)
      fmt_write |=> fmt == $past(w_value[adf_pkg::TP_HI:0]))
      else $error("format write not stored");
   chk_read_keeps: assert property ( // [R11]
      @(posedge clock) disable iff (reset)
      frame_end && is_read && !sw_reset |=> fmt == $past(fmt))
      else $error("read altered register");
   chk_bit_limit: assert property ( // [R12]
      @(posedge clock) disable iff (reset)
      bit_cnt <= FULL)
      else $error("more than sixteen bits taken");
   chk_extra_edges: assert property ( // [R12]
      @(posedge clock) disable iff (reset)
      sck_rise && bit_cnt == FULL |=> shift == $past(shift))
      else $error("edge past the sixteenth shifted data");

   // read back: after the eighth bit of a read, shift out the value MSB
   // first on each falling serial clock edge; open drain pulls only zeros
   wire sck_fall = selected & ~sck_sync[1] & sck_prev;
   logic [7:0] rd_shift;
   logic       rd_active;
   wire [7:0]  rd_value = (shift[6:0] == adf_pkg::IDX_FORMAT) ?
                          {2'h0, fmt} : 8'h00;
   always_ff @(posedge clock) begin
      if (reset || !selected) begin
         rd_shift  <= 8'h00;
         rd_active <= 1'b0;
      end else if (sck_fall && bit_cnt == HDR && shift[7]) begin
         rd_shift  <= rd_value;                              // [R11]
         rd_active <= 1'b1;
      end else if (sck_fall && rd_active) begin
         rd_shift  <= {rd_shift[6:0], 1'b1};
      end
   end
   assign serial_out_o  = 1'b0;
   assign serial_out_oe = rd_active & ~rd_shift[7];
   // a pulled line after deselect would fight the next bus user
   chk_quiet_deselect: assert property ( // [R11]
      @(posedge clock) disable iff (reset)
      !selected |=> !serial_out_oe)
      else $error("data line pulled while deselected");

   // field decode
   wire [2:0] tp      = fmt[adf_pkg::TP_HI:adf_pkg::TP_LO];
   wire       pol_en  = fmt[adf_pkg::POL_BIT];               // [R7]
   wire       scr_en  = fmt[adf_pkg::SCR_BIT];               // [R8]
   wire       sign_en = fmt[adf_pkg::SIGN_BIT];              // [R9]

   // toggles every sample so alternating patterns change each conversion
   logic phase;
   always_ff @(posedge clock) begin
      if (reset) begin
         phase <= 1'b0;
      end else begin
         phase <= ~phase;
      end
   end

   // coding: two's complement flips the msb of offset binary
   wire [13:0] coded = conv_sample ^ (sign_en ? adf_pkg::MSB_ONLY
                                              : 14'h0000);   // [R9]
   // randomizer: bits 13:1 xor with the lsb, reversible by the receiver
   wire [13:0] scrambled = scr_en ? (coded ^ {{13{coded[0]}}, 1'b0})
                                  : coded;                   // [R8]
   // alternate bit polarity inverts odd bits to cut supply ripple
   wire [13:0] polar = scrambled ^ (pol_en ? adf_pkg::ALT_MASK
                                           : 14'h0000);      // [R7]
   wire [14:0] normal_word = {conv_over, polar};

   // pattern mux; reserved codes fall back to normal data
   logic [14:0] next_word;
   always_comb begin
      unique case (tp)
         adf_pkg::TP_ZEROS:  next_word = adf_pkg::ALL_ZERO;  // [R2]
         adf_pkg::TP_ONES:   next_word = adf_pkg::ALL_ONE;   // [R3]
         adf_pkg::TP_CHECK:  next_word = phase ? adf_pkg::CHECK_B
                                               : adf_pkg::CHECK_A; // [R4]
         adf_pkg::TP_TOGGLE: next_word = phase ? adf_pkg::ALL_ONE
                                               : adf_pkg::ALL_ZERO; // [R5]
         default:            next_word = normal_word; // [R1] [R14] [R6]
      endcase
   end

   // registered outputs
   always_ff @(posedge clock) begin
      if (reset) begin
         sample_bits    <= '0;
         overrange_flag <= 1'b0;
      end else begin
         sample_bits    <= next_word[13:0];
         overrange_flag <= next_word[14];
      end
   end

   // output checks look one cycle after the select that drives them
   chk_zero_pattern: assert property ( // [R2]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_ZEROS |=> {overrange_flag, sample_bits} == 15'h0000)
      else $error("zero pattern wrong");
   chk_ones_pattern: assert property ( // [R3]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_ONES |=> {overrange_flag, sample_bits} == 15'h7fff)
      else $error("ones pattern wrong");
   // the first word after a switch still belongs to the old select
   chk_check_alt: assert property ( // [R4]
      @(posedge clock) disable iff (reset)
      (tp == adf_pkg::TP_CHECK)[*2] |=>
      ({overrange_flag, sample_bits} ^ $past({overrange_flag, sample_bits}))
      == 15'h7fff)
      else $error("checkerboard not alternating");
   chk_check_words: assert property ( // [R4]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_CHECK |=> {overrange_flag, sample_bits} == 15'h5555
      || {overrange_flag, sample_bits} == 15'h2aaa)
      else $error("checkerboard word wrong");
   chk_toggle_alt: assert property ( // [R5]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_TOGGLE ##1 tp == adf_pkg::TP_TOGGLE |=>
      {overrange_flag, sample_bits} == ~$past({overrange_flag, sample_bits}))
      else $error("toggle pattern not alternating");
   chk_toggle_words: assert property ( // [R5]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_TOGGLE |=> {overrange_flag, sample_bits} == 15'h0000
      || {overrange_flag, sample_bits} == 15'h7fff)
      else $error("toggle word wrong");
   chk_normal_path: assert property ( // [R1]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_OFF && !pol_en && !scr_en && !sign_en |=>
      sample_bits == $past(conv_sample) && overrange_flag == $past(conv_over))
      else $error("normal data altered");
   chk_sign_flip: assert property ( // [R9]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_OFF && !pol_en && !scr_en && sign_en |=>
      sample_bits == ($past(conv_sample) ^ 14'h2000))
      else $error("two's complement coding wrong");
   // a receiver undoes the randomizer by xoring bits 13:1 with bit 0
   chk_scramble_path: assert property ( // [R8]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_OFF && !pol_en && scr_en && !sign_en |=>
      (sample_bits ^ {{13{sample_bits[0]}}, 1'b0}) == $past(conv_sample))
      else $error("randomizer not reversible");
   chk_polarity_path: assert property ( // [R7]
      @(posedge clock) disable iff (reset)
      tp == adf_pkg::TP_OFF && pol_en && !scr_en && !sign_en |=>
      (sample_bits ^ 14'h2aaa) == $past(conv_sample))
      else $error("alternate bit polarity wrong");
endmodule

// >>> adf_capture.sv
`timescale 1ns/1ps
// capture logic: one 15-bit word per conversion clock
module adf_capture (
   input  wire logic        clock,          // conversion clock
   input  wire logic [13:0] sample_bits,    // formatted sample
   input  wire logic        overrange_flag, // formatted flag
   input  wire logic        serial_out_o,   // open-drain drive value
   input  wire logic        serial_out_oe,  // device pulls data low
   output logic      [14:0] word,           // last captured word
   output logic             sdo_line        // pulled-up data line
);
   // the pull-up wins whenever the device lets go
   assign sdo_line = serial_out_oe ? serial_out_o : 1'b1;
   // flag rides on top of the sample bits
   always_ff @(posedge clock) begin
      word <= {overrange_flag, sample_bits};
   end
endmodule

// >>> adc_output_data_formatter_tb_top.sv
`timescale 1ns/1ps
module adc_output_data_formatter_tb_top;
   logic        clock = 0, reset = 1, sel_n = 1, serial_clock = 0;
   logic        serial_in = 0, conv_over = 1;
   logic [13:0] conv_sample = 14'h1235;
   logic [13:0] sample_bits, m;
   logic        overrange_flag, serial_out_oe, sdo_line, serial_out_o, ok;
   logic [14:0] word, w0;
   logic [7:0]  rd;
   logic [2:0]  tp;
   int          bad_count = 0, cmp_count = 0;
   // 40 MHz conversion clock
   always #12.5 clock = ~clock;
   adf_formatter DUT (.clock(clock), .reset(reset),
      .conv_sample(conv_sample), .conv_over(conv_over), .sel_n(sel_n),
      .serial_clock(serial_clock), .serial_in(serial_in),
      .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
      .sample_bits(sample_bits), .overrange_flag(overrange_flag));
   adf_capture cap (.clock(clock), .sample_bits(sample_bits),
      .overrange_flag(overrange_flag), .serial_out_oe(serial_out_oe),
      .serial_out_o(serial_out_o),
      .word(word), .sdo_line(sdo_line));
   task automatic chk(string name, logic [14:0] seen, logic [14:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge clock);
   endtask
   // serial clock kept at clock/8 so the synchronisers see every edge
   task automatic frame(logic [15:0] w, int nbits);
      sel_n = 0;
      for (int i = 0; i < nbits; i++) begin
         serial_in = (i < 16) ? w[15-i] : 1'b1;
         serial_clock = 0;
         tick(4);
         if (i > 7 && i < 16) rd = {rd[6:0], sdo_line};
         serial_clock = 1;
         tick(4);
      end
      serial_clock = 0;
      tick(2);
      sel_n = 1;
      tick(8);
   endtask
   task automatic wr(logic [6:0] idx, logic [7:0] v);
      frame({1'b0, idx, v}, 16);
   endtask
   // entered with reset still held, so the reset word is still visible
   task automatic t_basic;
      chk("reset word", word, 15'h0000);
      reset = 0;
      tick(4);
      wr(adf_pkg::IDX_FORMAT, 8'hc0);
      chk("normal word", word, {conv_over, conv_sample});
      $display("test basic done");
   endtask
   // each coding control alone, sample with bit 0 set
   task automatic t_coding;
      for (int k = 0; k < 3; k++) begin
         wr(adf_pkg::IDX_FORMAT, 8'h01 << k);
         m = (k == 0) ? adf_pkg::MSB_ONLY : adf_pkg::ALT_MASK;
         if (k == 1) m = 14'h3ffe;
         w0 = {conv_over, conv_sample ^ m};
         chk("coded word", word, w0);
      end
      $display("test coding done");
   endtask
   // coding bits left on: patterns must pass through untouched
   task automatic t_fixed;
      wr(adf_pkg::IDX_FORMAT, {2'b00, adf_pkg::TP_ZEROS, 3'b111});
      chk("zeros", word, adf_pkg::ALL_ZERO);
      wr(adf_pkg::IDX_FORMAT, {2'b00, adf_pkg::TP_ONES, 3'b111});
      chk("ones", word, adf_pkg::ALL_ONE);
      $display("test fixed done");
   endtask
   task automatic t_alt;
      for (int k = 0; k < 2; k++) begin
         tp = k ? adf_pkg::TP_TOGGLE : adf_pkg::TP_CHECK;
         wr(adf_pkg::IDX_FORMAT, {2'b00, tp, 3'b111});
         w0 = word;
         tick(1);
         chk("alternation", w0 ^ word, 15'h7fff);
         ok = k ? (w0 == adf_pkg::ALL_ZERO || w0 == adf_pkg::ALL_ONE)
                : (w0 == adf_pkg::CHECK_A || w0 == adf_pkg::CHECK_B);
         chk("phase", 15'(ok), 15'h0001);
      end
      $display("test alternate done");
   endtask
   // read back must not write; edges past 16 are ignored
   task automatic t_read;
      wr(adf_pkg::IDX_FORMAT, 8'hd8);
      frame({1'b1, adf_pkg::IDX_FORMAT, 8'h00}, 16);
      chk("read value", rd, 15'h0018);
      chk("read no write", word, adf_pkg::ALL_ONE);
      frame({1'b0, adf_pkg::IDX_FORMAT, 8'h08}, 18);
      chk("long frame", word, adf_pkg::ALL_ZERO);
      $display("test read done");
   endtask
   task automatic t_soft;
      wr(adf_pkg::IDX_RESET, 8'h80);
      chk("soft reset", word, {conv_over, conv_sample});
      frame({1'b1, adf_pkg::IDX_FORMAT, 8'h00}, 16);
      chk("cleared reg", rd, 15'h0000);
      $display("test soft reset done");
   endtask
   // mid-run reset drops the outputs and clears the format register
   task automatic t_reset;
      wr(adf_pkg::IDX_FORMAT, {2'b00, adf_pkg::TP_ONES, 3'b000});
      reset = 1;
      tick(2);
      chk("mid reset word", word, adf_pkg::ALL_ZERO);
      reset = 0;
      tick(4);
      chk("after reset", word, {conv_over, conv_sample});
      $display("test reset done");
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      tick(12);
      t_basic;
      t_coding;
      t_fixed;
      t_alt;
      t_read;
      t_soft;
      t_reset;
      give_verdict;
   end
   // about 2000 cycles expected; cut off well beyond
   initial begin
      #400000;
      bad_count++;
      give_verdict;
   end
endmodule
